// File: wslc_pkg.sv
// Package of offsets, fields, reset values and states for the watchdog
package wslc_pkg;

  // Register offsets
  localparam logic [7:0] WSLC_CTRL_OFS = 8'h00;
  localparam logic [7:0] WSLC_STAT_OFS = 8'h01;

  // Control register fields
  localparam int WSLC_WIN_MSB = 7;
  localparam int WSLC_WIN_LSB = 4;
  localparam int WSLC_PER_MSB = 3;
  localparam int WSLC_PER_LSB = 0;

  // Status register fields
  localparam int WSLC_LOCK_BIT = 7;
  localparam int WSLC_BUSY_BIT = 0;
  localparam logic [7:0] WSLC_STAT_RST = 8'h00;

  // Period codes
  localparam logic [3:0] WSLC_CODE_OFF = 4'h0;
  localparam logic [3:0] WSLC_CODE_MAX = 4'hb;

  // Slow-clock lengths: code 1 gives 8 cycles, doubling per code up to code 11; higher codes stay at the maximum
  localparam int WSLC_CNT_W = 14;
  localparam logic [13:0] WSLC_LEN_BASE = 14'h0008;
  localparam logic [13:0] WSLC_LEN_MAX = 14'h2000;

  // Unlock window in CPU cycles after the key is written
  localparam logic [2:0] WSLC_GUARD_CYC = 3'h4;

  // Last sync stage; a kick or a control write crosses on the second slow-clock edge
  localparam logic [1:0] WSLC_SYNC_LAST = 2'h1;

  // Counter sequence states
  typedef enum logic [2:0] {
    WSLC_ST_OFF,
    WSLC_ST_NORMAL,
    WSLC_ST_CLOSED,
    WSLC_ST_OPEN,
    WSLC_ST_RESET
  } wslc_state_t;

endpackage

// File: wslc_watchdog.sv
// Watchdog with normal and window modes, write guard, lock and sync flags
`timescale 1ns/1ns
module wslc_watchdog
  import wslc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  input wire logic slow_tick_clock,
  input wire logic kick_instruction,
  input wire logic guard_unlock,
  input wire logic debug_mode,
  input wire logic debug_halt,
  input wire logic [7:0] boot_config_fuse,
  input wire logic boot_done,
  input wire logic reset_ack,
  output logic sys_reset_req
);

  // Length in slow cycles for a period or window code
  function automatic logic [13:0] code_len(input logic [3:0] code);
    logic [13:0] len;
    len = 14'h0000;
    if (code > WSLC_CODE_MAX)
      len = WSLC_LEN_MAX;
    else if (code != WSLC_CODE_OFF)
      len = WSLC_LEN_BASE << (code - 4'h1);
    return len;
  endfunction

  logic [7:0] ctrl;
  logic [7:0] ctrl_act;
  logic lock;
  logic busy;
  logic [1:0] ctrl_stage;
  logic kick_pend;
  logic [1:0] kick_stage;
  logic [2:0] guard_cnt;
  logic tick_q;
  logic boot_q;
  logic [WSLC_CNT_W-1:0] cnt;
  wslc_state_t state;

  logic tick;
  logic guard_open;
  logic ctrl_wr;
  logic stat_wr;
  logic ctrl_go;
  logic kick_go;
  logic [3:0] per_code;
  logic [3:0] win_code;
  logic [13:0] per_len;
  logic [13:0] win_len;

  // Tick edge, bus decode and lengths
  assign tick = slow_tick_clock & ~tick_q;
  assign guard_open = (guard_cnt != 3'h0);
  assign ctrl_wr = reg_we && (reg_addr == WSLC_CTRL_OFS);
  assign stat_wr = reg_we && (reg_addr == WSLC_STAT_OFS);
  assign ctrl_go = busy && tick && (ctrl_stage == WSLC_SYNC_LAST);
  assign kick_go = kick_pend && tick && (kick_stage == WSLC_SYNC_LAST);
  assign per_code = ctrl_act[WSLC_PER_MSB:WSLC_PER_LSB];
  assign win_code = ctrl_act[WSLC_WIN_MSB:WSLC_WIN_LSB];
  assign per_len = code_len(per_code);
  assign win_len = code_len(win_code);

  // Edge history of the tick and boot-done inputs
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tick_q <= 1'b0;
      boot_q <= 1'b0;
    end
    else
    begin
      tick_q <= slow_tick_clock;
      boot_q <= boot_done;
    end
  end

  // Unlock window opened by the key, closed by use or timeout
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      guard_cnt <= 3'h0;
    else if (guard_unlock)
      guard_cnt <= WSLC_GUARD_CYC;
    else if ((ctrl_wr || stat_wr) && guard_open)
      guard_cnt <= 3'h0;
    else if (guard_open)
      guard_cnt <= guard_cnt - 3'h1;
  end

  // Control register, guarded and lockable, reset from fuse
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ctrl <= boot_config_fuse;
    else if (ctrl_wr && guard_open && !lock)
      ctrl <= reg_wdata;
  end

  // Transfer of control into the slow domain
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      ctrl_stage <= 2'h0;
      ctrl_act <= boot_config_fuse;
    end
    else if (ctrl_wr && guard_open && !lock)
    begin
      busy <= 1'b1;
      ctrl_stage <= 2'h0;
    end
    else if (ctrl_go)
    begin
      busy <= 1'b0;
      ctrl_act <= ctrl;
    end
    else if (busy && tick)
      ctrl_stage <= ctrl_stage + 2'h1;
  end

  // Lock bit: guarded set, clear only in debug, auto set after boot
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      lock <= WSLC_STAT_RST[WSLC_LOCK_BIT];
    else if (boot_done && !boot_q && (ctrl[WSLC_PER_MSB:WSLC_PER_LSB] != WSLC_CODE_OFF))
      lock <= 1'b1;
    else if (stat_wr && guard_open)
    begin
      if (reg_wdata[WSLC_LOCK_BIT])
        lock <= 1'b1;
      else if (debug_mode)
        lock <= 1'b0;
    end
  end

  // Kick transfer; a second kick while pending is dropped
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      kick_pend <= 1'b0;
      kick_stage <= 2'h0;
    end
    else if (kick_go)
      kick_pend <= 1'b0;
    else if (kick_instruction && !kick_pend)
    begin
      kick_pend <= 1'b1;
      kick_stage <= 2'h0;
    end
    else if (kick_pend && tick)
      kick_stage <= kick_stage + 2'h1;
  end

  // Time-out sequence on slow ticks; a tick in debug halt clears the count except in the reset state
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= WSLC_ST_OFF;
      cnt <= '0;
      sys_reset_req <= 1'b0;
    end
    else if (state == WSLC_ST_RESET)
    begin
      if (reset_ack)
      begin
        sys_reset_req <= 1'b0;
        state <= WSLC_ST_OFF;
        cnt <= '0;
      end
    end
    else if (tick && debug_halt)
    begin
      cnt <= '0;
      state <= (per_code != WSLC_CODE_OFF) ? WSLC_ST_NORMAL : WSLC_ST_OFF;
    end
    else if (tick)
    begin
      if (per_code == WSLC_CODE_OFF)
      begin
        state <= WSLC_ST_OFF;
        cnt <= '0;
      end
      else
      begin
        unique case (state)
          WSLC_ST_OFF:
          begin
            state <= WSLC_ST_NORMAL;
            cnt <= '0;
          end
          WSLC_ST_NORMAL:
          begin
            if (kick_go)
            begin
              cnt <= '0;
              state <= (win_code != WSLC_CODE_OFF) ? WSLC_ST_CLOSED : WSLC_ST_NORMAL;
            end
            else if (cnt >= per_len - 14'h1)
            begin
              state <= WSLC_ST_RESET;
              sys_reset_req <= 1'b1;
            end
            else
              cnt <= cnt + 14'h1;
          end
          WSLC_ST_CLOSED:
          begin
            if (win_code == WSLC_CODE_OFF)
            begin
              state <= WSLC_ST_NORMAL;
              cnt <= '0;
            end
            else if (kick_go)
            begin
              state <= WSLC_ST_RESET;
              sys_reset_req <= 1'b1;
            end
            else if (cnt >= win_len - 14'h1)
            begin
              state <= WSLC_ST_OPEN;
              cnt <= '0;
            end
            else
              cnt <= cnt + 14'h1;
          end
          WSLC_ST_OPEN:
          begin
            if (kick_go)
            begin
              cnt <= '0;
              state <= (win_code != WSLC_CODE_OFF) ? WSLC_ST_CLOSED : WSLC_ST_NORMAL;
            end
            else if (cnt >= per_len - 14'h1)
            begin
              state <= WSLC_ST_RESET;
              sys_reset_req <= 1'b1;
            end
            else
              cnt <= cnt + 14'h1;
          end
          WSLC_ST_RESET:
            state <= WSLC_ST_RESET;
        endcase
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_re && (reg_addr == WSLC_CTRL_OFS))
      reg_rdata <= ctrl;
    else if (reg_re && (reg_addr == WSLC_STAT_OFS))
      reg_rdata <= {lock, 6'h00, busy};
    else
      reg_rdata <= 8'h00;
  end

  // Checks
  property p_busy_set;
    @(posedge clk) disable iff (!rst_n)
      (ctrl_wr && guard_open && !lock) |=> busy;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("pending flag not set");

  property p_busy_clr;
    @(posedge clk) disable iff (!rst_n)
      (ctrl_go && !ctrl_wr) |=> (!busy && (ctrl_act == $past(ctrl)));
  endproperty
  a_busy_clr: assert property (p_busy_clr) else $error("transfer did not finish");

  property p_unguarded;
    @(posedge clk) disable iff (!rst_n)
      (ctrl_wr && !guard_open) |=> $stable(ctrl);
  endproperty
  a_unguarded: assert property (p_unguarded) else $error("unguarded write took");

  property p_guard_len;
    @(posedge clk) disable iff (!rst_n)
      (guard_unlock ##1 (!guard_unlock && !ctrl_wr && !stat_wr) [*4]) |=> !guard_open;
  endproperty
  a_guard_len: assert property (p_guard_len) else $error("guard window too long");

  property p_locked_ctrl;
    @(posedge clk) disable iff (!rst_n)
      lock |=> $stable(ctrl);
  endproperty
  a_locked_ctrl: assert property (p_locked_ctrl) else $error("locked control changed");

  property p_lock_keep;
    @(posedge clk) disable iff (!rst_n)
      (lock && !debug_mode) |=> lock;
  endproperty
  a_lock_keep: assert property (p_lock_keep) else $error("lock cleared outside debug");

  property p_halt_clr;
    @(posedge clk) disable iff (!rst_n)
      (tick && debug_halt && !sys_reset_req) |=> (cnt == '0 && state != WSLC_ST_CLOSED);
  endproperty
  a_halt_clr: assert property (p_halt_clr) else $error("halt did not clear");

  property p_kick_drop;
    @(posedge clk) disable iff (!rst_n)
      (kick_pend && kick_instruction && !tick) |=> (kick_pend && $stable(kick_stage));
  endproperty
  a_kick_drop: assert property (p_kick_drop) else $error("second kick restarted");

  property p_closed_kick;
    @(posedge clk) disable iff (!rst_n)
      (state == WSLC_ST_CLOSED && kick_go && !debug_halt && win_code != WSLC_CODE_OFF
       && per_code != WSLC_CODE_OFF) |=> sys_reset_req;
  endproperty
  a_closed_kick: assert property (p_closed_kick) else $error("closed kick missed");

  property p_req_hold;
    @(posedge clk) disable iff (!rst_n)
      (sys_reset_req && !reset_ack) |=> sys_reset_req;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("reset request dropped");

  property p_kick_slow;
    @(posedge clk) disable iff (!rst_n)
      (kick_instruction && !kick_pend) |=> !kick_go;
  endproperty
  a_kick_slow: assert property (p_kick_slow) else $error("kick crossed too fast");

  c_window_seq: cover property (@(posedge clk) disable iff (!rst_n)
    state == WSLC_ST_CLOSED ##[1:1000] state == WSLC_ST_OPEN);
  c_expiry: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(sys_reset_req));
  c_lock_debug: cover property (@(posedge clk) disable iff (!rst_n)
    lock ##1 !lock);
  c_ctrl_sync: cover property (@(posedge clk) disable iff (!rst_n)
    ctrl_go);

endmodule // wslc_watchdog

// File: wslc_cpu_model.sv
// CPU-side model: register accesses, unlock pulses and kicks
`timescale 1ns/1ns
module wslc_cpu_model
  import wslc_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_we,
  output logic reg_re,
  output logic guard_unlock,
  output logic kick_instruction
);
  // Idle bus at time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_we = 1'b0;
    reg_re = 1'b0;
    guard_unlock = 1'b0;
    kick_instruction = 1'b0;
  end

  // One read strobe; data taken in the cycle after it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask

  // Optional unlock pulse, then the write in the very next cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic g);
    logic [7:0] s;
    s = 8'h01;
    // Control writes wait until a transfer has finished
    for (int n = 0; n < 40 && a == WSLC_CTRL_OFS && s[WSLC_BUSY_BIT]; n++)
      rd(WSLC_STAT_OFS, s);
    @(posedge clk);
    guard_unlock <= g;
    @(posedge clk);
    guard_unlock <= 1'b0;
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // One-cycle kick pulse
  task automatic kick();
    @(posedge clk);
    kick_instruction <= 1'b1;
    @(posedge clk);
    kick_instruction <= 1'b0;
  endtask
endmodule // wslc_cpu_model

// File: test_wslc_watchdog.sv
// Bench for the watchdog: register rows, time-outs, window, halt and lock
`timescale 1ns/1ns
module test_wslc_watchdog
  import wslc_pkg::*;
();
  typedef struct {logic g; logic [7:0] a; logic [7:0] d; logic [7:0] e;} wslc_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic slow_tick_clock;
  logic [1:0] tick_div = 2'h0;
  logic debug_mode = 1'b0;
  logic debug_halt = 1'b0;
  logic boot_done = 1'b0;
  logic reset_ack = 1'b0;
  logic [7:0] boot_config_fuse = 8'h30;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic reg_we, reg_re, guard_unlock, kick_instruction, sys_reset_req;
  int num_errors = 0;
  int cmp_count = 0;
  // Rows: guarded, address, data, expected read-back
  wslc_row_t rows [4] = '{
    '{1'b1, 8'h07, 8'hff, 8'h00},
    '{1'b0, WSLC_CTRL_OFS, 8'h23, 8'h30},
    '{1'b1, WSLC_CTRL_OFS, 8'h02, 8'h02},
    '{1'b1, WSLC_CTRL_OFS, 8'h30, 8'h30}};

  // System clock; fast slow tick rises every fourth clock, changed on the edge
  always #25 clk = ~clk;
  always @(posedge clk) tick_div <= tick_div + 2'h1;
  assign slow_tick_clock = tick_div[1];

  wslc_watchdog i_wslc_watchdog (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .slow_tick_clock(slow_tick_clock), .kick_instruction(kick_instruction),
    .guard_unlock(guard_unlock), .debug_mode(debug_mode), .debug_halt(debug_halt),
    .boot_config_fuse(boot_config_fuse), .boot_done(boot_done), .reset_ack(reset_ack),
    .sys_reset_req(sys_reset_req));
  wslc_cpu_model i_wslc_cpu_model (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .guard_unlock(guard_unlock),
    .kick_instruction(kick_instruction));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_req(input int n);
    for (int i = 0; i < n && sys_reset_req !== 1'b1; i++)
      @(posedge clk);
    #1;
  endtask

  // Acknowledge the request and see it drop
  task automatic ack();
    @(posedge clk);
    reset_ack <= 1'b1;
    @(posedge clk);
    reset_ack <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({7'h00, sys_reset_req}, 8'h00);
  endtask

  task automatic summarize();
    if (num_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    #300000;
    num_errors++;
    summarize();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    i_wslc_cpu_model.rd(WSLC_CTRL_OFS, v);
    chk(v, 8'h30);
    i_wslc_cpu_model.rd(WSLC_STAT_OFS, v);
    chk(v, WSLC_STAT_RST);
    foreach (rows[i])
    begin
      i_wslc_cpu_model.wr(rows[i].a, rows[i].d, rows[i].g);
      i_wslc_cpu_model.rd(WSLC_STAT_OFS, v);
      chk(v, {7'h00, rows[i].g && rows[i].a == WSLC_CTRL_OFS});
      i_wslc_cpu_model.rd(rows[i].a, v);
      chk(v, rows[i].e);
    end
    // Let the last transfer cross two slow ticks before the flag is read
    repeat (8) @(posedge clk);
    i_wslc_cpu_model.rd(WSLC_STAT_OFS, v);
    chk(v, 8'h00);
    // Regular kicks hold off the time-out; a kick while one crosses is dropped
    i_wslc_cpu_model.wr(WSLC_CTRL_OFS, 8'h01, 1'b1);
    repeat (12)
    begin
      i_wslc_cpu_model.kick();
      i_wslc_cpu_model.kick();
      repeat (12) @(posedge clk);
      #1;
      chk({7'h00, sys_reset_req}, 8'h00);
    end
    repeat (12) @(posedge clk);
    #1;
    chk({7'h00, sys_reset_req}, 8'h00);
    wait_req(40);
    chk({7'h00, sys_reset_req}, 8'h01);
    repeat (20) @(posedge clk);
    #1;
    chk({7'h00, sys_reset_req}, 8'h01);
    ack();
    // Window mode: first kick starts closed, open kick is fine, early kick trips
    i_wslc_cpu_model.wr(WSLC_CTRL_OFS, 8'h11, 1'b1);
    repeat (12) @(posedge clk);
    i_wslc_cpu_model.kick();
    repeat (16) @(posedge clk);
    #1;
    chk({7'h00, sys_reset_req}, 8'h00);
    repeat (24) @(posedge clk);
    i_wslc_cpu_model.kick();
    repeat (12) @(posedge clk);
    #1;
    chk({7'h00, sys_reset_req}, 8'h00);
    i_wslc_cpu_model.kick();
    wait_req(20);
    chk({7'h00, sys_reset_req}, 8'h01);
    ack();
    // Halt keeps clearing the count; on release a plain period runs
    @(posedge clk);
    debug_halt <= 1'b1;
    repeat (200) @(posedge clk);
    debug_halt <= 1'b0;
    #1;
    chk({7'h00, sys_reset_req}, 8'h00);
    wait_req(50);
    chk({7'h00, sys_reset_req}, 8'h01);
    ack();
    // Lock freezes control and clears only in debug mode
    i_wslc_cpu_model.wr(WSLC_CTRL_OFS, 8'h30, 1'b1);
    i_wslc_cpu_model.wr(WSLC_STAT_OFS, 8'h80, 1'b1);
    i_wslc_cpu_model.wr(WSLC_CTRL_OFS, 8'h05, 1'b1);
    i_wslc_cpu_model.rd(WSLC_CTRL_OFS, v);
    chk(v, 8'h30);
    i_wslc_cpu_model.wr(WSLC_STAT_OFS, 8'h00, 1'b1);
    i_wslc_cpu_model.rd(WSLC_STAT_OFS, v);
    chk(v & 8'h80, 8'h80);
    @(posedge clk);
    debug_mode <= 1'b1;
    i_wslc_cpu_model.wr(WSLC_STAT_OFS, 8'h00, 1'b1);
    debug_mode <= 1'b0;
    i_wslc_cpu_model.wr(WSLC_STAT_OFS, 8'h80, 1'b0);
    i_wslc_cpu_model.rd(WSLC_STAT_OFS, v);
    chk(v & 8'h80, 8'h00);
    // Boot finishing with a live period sets the lock
    i_wslc_cpu_model.wr(WSLC_CTRL_OFS, 8'h0b, 1'b1);
    boot_done <= 1'b1;
    repeat (2) @(posedge clk);
    i_wslc_cpu_model.rd(WSLC_STAT_OFS, v);
    chk(v & 8'h80, 8'h80);
    summarize();
  end
endmodule // test_wslc_watchdog
